//--- design/cpr_pkg.sv
// constants of the content protection register bank
package cpr_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_POLARITY = 8'h1b;
	localparam logic [7:0] IDX_IDENT = 8'h1e;
	localparam logic [7:0] IDX_CAPREV = 8'h1f;
	localparam logic [7:0] IDX_RXKEY = 8'h80;
	localparam logic [7:0] IDX_LINKCHK = 8'h85;
	localparam logic [7:0] IDX_ENHCHK = 8'h87;
	localparam logic [7:0] IDX_NONCE = 8'h88;
	localparam logic [7:0] IDX_TXKEY = 8'h90;
	localparam logic [7:0] IDX_CTRL = 8'h95;
	localparam logic [7:0] IDX_STATUS = 8'h96;
	localparam logic [7:0] IDX_RXCAPS = 8'h97;
	localparam logic [7:0] IDX_SEED = 8'h98;
	localparam logic [7:0] IDX_PIXEL = 8'h9d;
	localparam logic [7:0] IDX_DIGEST = 8'ha0;
	// register sizes in bytes
	localparam logic [7:0] LEN_KEY = 8'h05;
	localparam logic [7:0] LEN_NONCE = 8'h08;
	localparam logic [7:0] LEN_PIXEL = 8'h03;
	localparam logic [7:0] LEN_DIGEST = 8'h04;
	// field positions
	localparam int BIT_INV_SCK = 7;
	localparam int BIT_INV_WS = 6;
	localparam int BIT_POWERDOWN = 7;
	localparam int BIT_INT_COMPARE = 6;
	localparam int BIT_MUTE_AUDIO = 5;
	localparam int BIT_SUB_VIDEO = 4;
	localparam int BIT_ENGINE_RESET = 3;
	localparam int BIT_BEGIN_HS = 2;
	localparam int BIT_VSYNC_SEEN = 1;
	localparam int BIT_CIPHER_ON = 0;
	localparam int BIT_REPEATER = 0;
	// reset values, fixed read values and the warm-up done count
	localparam logic [5:0] POLARITY_RSVD = 6'h10;
	localparam logic [15:0] LINKCHK_RST = 16'hffff;
	localparam logic [7:0] ENHCHK_RST = 8'hff;
	localparam logic [1:0] WARM_DONE = 2'h3;
	// ahb transfer types and response
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage

//--- design/cpr_regs.sv
// register bank and datapath controls of the content protection block
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module cpr_regs #(
	parameter logic [7:0] DEVICE_ID = 8'h5a, // arbitrary value
	parameter logic CAPABLE = 1'b1,
	parameter logic [3:0] REVISION = 4'h1 // arbitrary value
)(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [9:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	input wire logic sck_in,
	input wire logic ws_in,
	input wire logic vsync_in,
	output logic sck_out,
	output logic ws_out,
	input wire logic [31:0] audio_sample_in,
	output logic [31:0] audio_sample_out,
	input wire logic [23:0] video_pixel_in,
	output logic [23:0] video_pixel_out,
	input wire logic [15:0] tx_link_check,
	input wire logic [7:0] tx_enhanced_check,
	input wire logic [31:0] tx_digest_word0,
	input wire logic [63:0] session_nonce,
	input wire logic [39:0] transmitter_key_vector,
	input wire logic receiver_key_bad,
	input wire logic engine_reset_done,
	input wire logic handshake_began,
	output logic content_protect_powerdown,
	output logic internal_compare_select,
	output logic protection_engine_reset,
	output logic begin_handshake,
	output logic cipher_on,
	output logic repeater,
	output logic [39:0] receiver_key_vector,
	output logic [39:0] rng_seed_value
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] warm;
		logic sck_s1;
		logic sck_s2;
		logic ws_s1;
		logic ws_s2;
		logic vs_s1;
		logic vs_s2;
		logic vs_prev;
		logic sck_out;
		logic ws_out;
		logic [31:0] audio;
		logic [23:0] pixel;
		logic inv_sck;
		logic inv_ws;
		logic powerdown;
		logic int_cmp;
		logic mute;
		logic sub_video;
		logic eng_rst;
		logic hs;
		logic vs_seen;
		logic cipher;
		logic repeater;
		logic [4:0][7:0] rx_key;
		logic [1:0][7:0] link_rx;
		logic [7:0] enh_rx;
		logic [4:0][7:0] seed;
		logic [2:0][7:0] sub_pixel;
		logic [3:0][7:0] digest_rx;
		logic dph;
		logic dwr;
		logic [7:0] didx;
		logic ready;
		logic [1:0] resp;
		logic [31:0] rdata;
	} cpr_state_t;

	cpr_state_t st;
	cpr_state_t next_st;
	logic [7:0] wb;
	logic [7:0] rb;
	logic [7:0] aidx;
	logic [7:0] off;
	logic [15:0] tx_link;
	logic [3:0][7:0] tx_dig;
	logic [7:0][7:0] nonce_b;
	logic [4:0][7:0] txkey_b;

	assign tx_link = tx_link_check;
	assign tx_dig = tx_digest_word0;
	assign nonce_b = session_nonce;
	assign txkey_b = transmitter_key_vector;
	assign wb = hwdata[7:0];
	assign aidx = haddr[9:2];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		next_st = st;
		rb = 8'h00;
		off = 8'h00;
		next_st.warm = (st.warm == cpr_pkg::WARM_DONE) ? st.warm
			: 2'(st.warm + 2'h1);
		next_st.sck_s1 = sck_in;
		next_st.sck_s2 = st.sck_s1;
		next_st.ws_s1 = ws_in;
		next_st.ws_s2 = st.ws_s1;
		next_st.vs_s1 = vsync_in;
		next_st.vs_s2 = st.vs_s1;
		next_st.vs_prev = st.vs_s2;
		next_st.sck_out = st.sck_s2 ^ st.inv_sck;
		next_st.ws_out = st.ws_s2 ^ st.inv_ws;
		next_st.audio = st.mute ? 32'h0000_0000 : audio_sample_in;
		// red low byte, green middle, blue top
		next_st.pixel = st.sub_video ? st.sub_pixel : video_pixel_in;
		if (engine_reset_done)
			next_st.eng_rst = 1'b0;
		if (handshake_began)
			next_st.hs = 1'b0;
		// data phase write
		if (st.dph && st.dwr)
		begin
			if (st.didx == cpr_pkg::IDX_POLARITY)
			begin
				next_st.inv_sck = wb[cpr_pkg::BIT_INV_SCK];
				next_st.inv_ws = wb[cpr_pkg::BIT_INV_WS];
			end
			else if (st.didx >= cpr_pkg::IDX_RXKEY
				&& st.didx < cpr_pkg::IDX_RXKEY + cpr_pkg::LEN_KEY)
			begin
				off = st.didx - cpr_pkg::IDX_RXKEY;
				next_st.rx_key[off[2:0]] = wb;
			end
			else if (st.didx == cpr_pkg::IDX_LINKCHK && st.int_cmp)
				next_st.link_rx[0] = wb;
			else if (st.didx == cpr_pkg::IDX_LINKCHK + 8'h01 && st.int_cmp)
				next_st.link_rx[1] = wb;
			else if (st.didx == cpr_pkg::IDX_ENHCHK && st.int_cmp)
				next_st.enh_rx = wb;
			else if (st.didx == cpr_pkg::IDX_CTRL)
			begin
				next_st.powerdown = wb[cpr_pkg::BIT_POWERDOWN];
				next_st.int_cmp = wb[cpr_pkg::BIT_INT_COMPARE];
				next_st.mute = wb[cpr_pkg::BIT_MUTE_AUDIO];
				next_st.sub_video = wb[cpr_pkg::BIT_SUB_VIDEO];
				if (wb[cpr_pkg::BIT_ENGINE_RESET])
					next_st.eng_rst = 1'b1;
				if (wb[cpr_pkg::BIT_BEGIN_HS])
					next_st.hs = 1'b1;
				if (!wb[cpr_pkg::BIT_VSYNC_SEEN])
					next_st.vs_seen = 1'b0;
				next_st.cipher = wb[cpr_pkg::BIT_CIPHER_ON];
			end
			else if (st.didx == cpr_pkg::IDX_RXCAPS)
				next_st.repeater = wb[cpr_pkg::BIT_REPEATER];
			else if (st.didx >= cpr_pkg::IDX_SEED
				&& st.didx < cpr_pkg::IDX_SEED + cpr_pkg::LEN_KEY)
			begin
				off = st.didx - cpr_pkg::IDX_SEED;
				next_st.seed[off[2:0]] = wb;
			end
			else if (st.didx >= cpr_pkg::IDX_PIXEL
				&& st.didx < cpr_pkg::IDX_PIXEL + cpr_pkg::LEN_PIXEL)
			begin
				off = st.didx - cpr_pkg::IDX_PIXEL;
				next_st.sub_pixel[off[1:0]] = wb;
			end
			else if (st.didx >= cpr_pkg::IDX_DIGEST
				&& st.didx < cpr_pkg::IDX_DIGEST + cpr_pkg::LEN_DIGEST
				&& st.int_cmp)
			begin
				off = st.didx - cpr_pkg::IDX_DIGEST;
				next_st.digest_rx[off[1:0]] = wb;
			end
		end
		// a falling edge beats a clearing write in the same cycle
		if (st.vs_prev && !st.vs_s2)
			next_st.vs_seen = 1'b1;
		// read mux over the updated state so a write is seen at once
		if (aidx == cpr_pkg::IDX_POLARITY)
			rb = {next_st.inv_sck, next_st.inv_ws, cpr_pkg::POLARITY_RSVD};
		else if (aidx == cpr_pkg::IDX_IDENT)
			rb = DEVICE_ID;
		else if (aidx == cpr_pkg::IDX_CAPREV)
			rb = {3'b000, CAPABLE, REVISION};
		else if (aidx >= cpr_pkg::IDX_RXKEY
			&& aidx < cpr_pkg::IDX_RXKEY + cpr_pkg::LEN_KEY)
		begin
			off = aidx - cpr_pkg::IDX_RXKEY;
			rb = next_st.rx_key[off[2:0]];
		end
		else if (aidx == cpr_pkg::IDX_LINKCHK)
			rb = next_st.int_cmp ? next_st.link_rx[0] : tx_link[7:0];
		else if (aidx == cpr_pkg::IDX_LINKCHK + 8'h01)
			rb = next_st.int_cmp ? next_st.link_rx[1] : tx_link[15:8];
		else if (aidx == cpr_pkg::IDX_ENHCHK)
			rb = next_st.int_cmp ? next_st.enh_rx : tx_enhanced_check;
		else if (aidx >= cpr_pkg::IDX_NONCE
			&& aidx < cpr_pkg::IDX_NONCE + cpr_pkg::LEN_NONCE)
		begin
			off = aidx - cpr_pkg::IDX_NONCE;
			rb = nonce_b[off[2:0]];
		end
		else if (aidx >= cpr_pkg::IDX_TXKEY
			&& aidx < cpr_pkg::IDX_TXKEY + cpr_pkg::LEN_KEY)
		begin
			off = aidx - cpr_pkg::IDX_TXKEY;
			rb = txkey_b[off[2:0]];
		end
		else if (aidx == cpr_pkg::IDX_CTRL)
			rb = {next_st.powerdown, next_st.int_cmp, next_st.mute,
				next_st.sub_video, next_st.eng_rst, next_st.hs,
				next_st.vs_seen, next_st.cipher};
		else if (aidx == cpr_pkg::IDX_STATUS)
			rb = {4'h0,
				next_st.int_cmp && (next_st.digest_rx == tx_dig),
				next_st.int_cmp && (next_st.enh_rx == tx_enhanced_check),
				next_st.int_cmp && (next_st.link_rx == tx_link),
				receiver_key_bad};
		else if (aidx == cpr_pkg::IDX_RXCAPS)
			rb = {7'h00, next_st.repeater};
		else if (aidx >= cpr_pkg::IDX_SEED
			&& aidx < cpr_pkg::IDX_SEED + cpr_pkg::LEN_KEY)
		begin
			off = aidx - cpr_pkg::IDX_SEED;
			rb = next_st.seed[off[2:0]];
		end
		else if (aidx >= cpr_pkg::IDX_PIXEL
			&& aidx < cpr_pkg::IDX_PIXEL + cpr_pkg::LEN_PIXEL)
		begin
			off = aidx - cpr_pkg::IDX_PIXEL;
			rb = next_st.sub_pixel[off[1:0]];
		end
		else if (aidx >= cpr_pkg::IDX_DIGEST
			&& aidx < cpr_pkg::IDX_DIGEST + cpr_pkg::LEN_DIGEST)
		begin
			off = aidx - cpr_pkg::IDX_DIGEST;
			rb = next_st.int_cmp ? next_st.digest_rx[off[1:0]]
				: tx_dig[off[1:0]];
		end
		// address phase capture
		if (hready)
		begin
			next_st.dph = hsel && (htrans == cpr_pkg::HTRANS_NONSEQ);
			next_st.dwr = hwrite;
			next_st.didx = aidx;
			if (hsel && (htrans == cpr_pkg::HTRANS_NONSEQ) && !hwrite)
				next_st.rdata = {24'h00_0000, rb};
		end
		next_st.ready = 1'b1;
		next_st.resp = cpr_pkg::HRESP_OKAY;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st <= '0;
			st.link_rx <= cpr_pkg::LINKCHK_RST;
			st.enh_rx <= cpr_pkg::ENHCHK_RST;
		end
		else
			st <= next_st;
	end

	assign hreadyout = st.ready;
	assign hresp = st.resp;
	assign hrdata = st.rdata;
	assign sck_out = st.sck_out;
	assign ws_out = st.ws_out;
	assign audio_sample_out = st.audio;
	assign video_pixel_out = st.pixel;
	assign content_protect_powerdown = st.powerdown;
	assign internal_compare_select = st.int_cmp;
	assign protection_engine_reset = st.eng_rst;
	assign begin_handshake = st.hs;
	assign cipher_on = st.cipher;
	assign repeater = st.repeater;
	assign receiver_key_vector = st.rx_key;
	assign rng_seed_value = st.seed;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_sck_invert: assert property (
		(st.warm == cpr_pkg::WARM_DONE) |->
		sck_out == ($past(sck_in, 3) ^ $past(st.inv_sck)))
		else $error("audio bit clock polarity wrong");
	a_ws_invert: assert property (
		(st.warm == cpr_pkg::WARM_DONE) |->
		ws_out == ($past(ws_in, 3) ^ $past(st.inv_ws)))
		else $error("word select polarity wrong");
	a_pd_write: assert property (
		st.dph && st.dwr && st.didx == cpr_pkg::IDX_CTRL |=>
		content_protect_powerdown ==
		$past(hwdata[cpr_pkg::BIT_POWERDOWN]))
		else $error("powerdown bit not written");
	a_link_locked: assert property (
		!st.int_cmp |=> st.link_rx == $past(st.link_rx))
		else $error("link check value written while read only");
	a_mute_audio: assert property (
		$past(st.mute) && st.warm == cpr_pkg::WARM_DONE |->
		audio_sample_out == 32'h0000_0000)
		else $error("audio not muted");
	a_sub_video: assert property (
		$past(st.sub_video) && st.warm == cpr_pkg::WARM_DONE |->
		video_pixel_out == $past(st.sub_pixel))
		else $error("substitute pixel not sent");
	a_reset_clear: assert property (
		protection_engine_reset && engine_reset_done
		&& !(st.dph && st.dwr && st.didx == cpr_pkg::IDX_CTRL)
		|=> !protection_engine_reset)
		else $error("engine reset did not self clear");
	a_hs_clear: assert property (
		begin_handshake && handshake_began
		&& !(st.dph && st.dwr && st.didx == cpr_pkg::IDX_CTRL)
		|=> !begin_handshake)
		else $error("handshake bit did not self clear");
	a_vsync_seen: assert property (
		st.vs_prev && !st.vs_s2 |=> st.vs_seen)
		else $error("vertical sync fall not flagged");
	a_cmp_gate: assert property (
		hsel && hready && htrans == cpr_pkg::HTRANS_NONSEQ && !hwrite
		&& aidx == cpr_pkg::IDX_STATUS && !next_st.int_cmp
		|=> hrdata[3:1] == 3'b000)
		else $error("match flag set without internal compare");
	a_cipher_write: assert property (
		st.dph && st.dwr && st.didx == cpr_pkg::IDX_CTRL |=>
		cipher_on == $past(hwdata[cpr_pkg::BIT_CIPHER_ON]))
		else $error("cipher bit not written");
	a_key_bad: assert property (
		hsel && hready && htrans == cpr_pkg::HTRANS_NONSEQ && !hwrite
		&& aidx == cpr_pkg::IDX_STATUS |=>
		hrdata[0] == $past(receiver_key_bad))
		else $error("receiver key status bit wrong");

endmodule

//--- testbench/content_protection_regs_tb.sv
// self-checking testbench of the content protection register bank
`timescale 1ns/1ps
module content_protection_regs_tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam logic [7:0] ID_VAL = 8'h5a; // arbitrary value
	localparam logic [3:0] REV_VAL = 4'h3; // arbitrary value
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [9:0] haddr = 10'h000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hready;
	logic hreadyout;
	logic [1:0] hresp;
	logic [31:0] hrdata;
	logic sck_in = 1'b0;
	logic ws_in = 1'b0;
	logic vsync_in = 1'b0;
	logic sck_out;
	logic ws_out;
	logic [31:0] audio_sample_in = 32'h1234_5678;
	logic [31:0] audio_sample_out;
	logic [23:0] video_pixel_in = 24'h0a_0b0c;
	logic [23:0] video_pixel_out;
	logic [15:0] tx_link_check = 16'h1234;
	logic [7:0] tx_enhanced_check = 8'h56;
	logic [31:0] tx_digest_word0 = 32'h89ab_cdef;
	logic [63:0] session_nonce = 64'h0102_0304_0506_0708;
	logic [39:0] transmitter_key_vector = 40'h11_2233_4455;
	logic receiver_key_bad = 1'b0;
	logic engine_reset_done = 1'b0;
	logic handshake_began = 1'b0;
	logic content_protect_powerdown;
	logic internal_compare_select;
	logic protection_engine_reset;
	logic begin_handshake;
	logic cipher_on;
	logic repeater;
	logic [39:0] receiver_key_vector;
	logic [39:0] rng_seed_value;
	int num_errors = 0;
	int comparisons = 0;

	assign hready = hreadyout;
	always #20 hclk = ~hclk;

	cpr_regs #(.DEVICE_ID(ID_VAL), .CAPABLE(1'b1), .REVISION(REV_VAL)) uut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .sck_in, .ws_in, .vsync_in,
		.sck_out, .ws_out, .audio_sample_in, .audio_sample_out,
		.video_pixel_in, .video_pixel_out, .tx_link_check, .tx_enhanced_check,
		.tx_digest_word0, .session_nonce, .transmitter_key_vector,
		.receiver_key_bad, .engine_reset_done, .handshake_began,
		.content_protect_powerdown, .internal_compare_select,
		.protection_engine_reset, .begin_handshake, .cipher_on, .repeater,
		.receiver_key_vector, .rng_seed_value
	);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic close_out;
		if (num_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge hclk);
		end
		if (hready !== 1'b1)
		begin
			num_errors++;
			close_out;
		end
	endtask

	// one single-word transfer: address phase, then data phase
	task automatic bus(input logic [7:0] idx, input logic wr,
		input logic [7:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= cpr_pkg::HTRANS_NONSEQ;
		haddr <= {idx, 2'h0};
		hwrite <= wr;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		wait_ready;
		q = hrdata;
		check(64'(hresp), 64'(cpr_pkg::HRESP_OKAY));
	endtask

	task automatic wr_n(input logic [7:0] idx, input int n,
		input logic [63:0] v);
		logic [31:0] q;
		for (int i = 0; i < n; i++)
			bus(idx + 8'(i), 1'b1, v[8*i +: 8], q);
	endtask

	task automatic exp_reg(input logic [7:0] idx, input int n,
		input logic [63:0] exp);
		logic [31:0] q;
		logic [63:0] v;
		v = 64'h0000_0000_0000_0000;
		for (int i = 0; i < n; i++)
		begin
			bus(idx + 8'(i), 1'b0, 8'h00, q);
			v[8*i +: 8] = q[7:0];
			if (q[31:8] !== 24'h00_0000)
				v[63:56] = 8'hee;
		end
		check(v, exp);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		exp_reg(cpr_pkg::IDX_POLARITY, 1, 64'h10);
		exp_reg(cpr_pkg::IDX_IDENT, 1, 64'(ID_VAL));
		exp_reg(cpr_pkg::IDX_CAPREV, 1, 64'({4'h1, REV_VAL}));
		exp_reg(cpr_pkg::IDX_RXKEY, 5, 64'h0);
		exp_reg(cpr_pkg::IDX_CTRL, 1, 64'h0);
		exp_reg(cpr_pkg::IDX_STATUS, 1, 64'h0);
		exp_reg(cpr_pkg::IDX_RXCAPS, 1, 64'h0);
		exp_reg(cpr_pkg::IDX_SEED, 5, 64'h0);
		exp_reg(cpr_pkg::IDX_PIXEL, 3, 64'h0);
		// read-only places and transmitter values ignore writes
		wr_n(cpr_pkg::IDX_IDENT, 2, 64'hffff);
		wr_n(cpr_pkg::IDX_NONCE, 8, 64'h0);
		wr_n(cpr_pkg::IDX_TXKEY, 5, 64'h0);
		wr_n(cpr_pkg::IDX_LINKCHK, 3, 64'h0);
		wr_n(cpr_pkg::IDX_DIGEST, 4, 64'h0);
		wr_n(8'h50, 1, 64'hff);
		exp_reg(cpr_pkg::IDX_IDENT, 1, 64'(ID_VAL));
		exp_reg(cpr_pkg::IDX_CAPREV, 1, 64'({4'h1, REV_VAL}));
		exp_reg(cpr_pkg::IDX_NONCE, 8, session_nonce);
		exp_reg(cpr_pkg::IDX_TXKEY, 5, 64'(transmitter_key_vector));
		exp_reg(cpr_pkg::IDX_LINKCHK, 2, 64'h1234);
		exp_reg(cpr_pkg::IDX_ENHCHK, 1, 64'h56);
		exp_reg(cpr_pkg::IDX_DIGEST, 4, 64'h89ab_cdef);
		exp_reg(8'h50, 1, 64'h0);
		// audio pin polarity
		wr_n(cpr_pkg::IDX_POLARITY, 1, 64'hc0);
		exp_reg(cpr_pkg::IDX_POLARITY, 1, 64'hd0);
		sck_in <= 1'b1;
		repeat (5) @(posedge hclk);
		check(64'(sck_out), 64'h0);
		check(64'(ws_out), 64'h1);
		wr_n(cpr_pkg::IDX_POLARITY, 1, 64'h0);
		repeat (5) @(posedge hclk);
		check(64'(sck_out), 64'h1);
		check(64'(ws_out), 64'h0);
		// key, seed and substitute pixel
		wr_n(cpr_pkg::IDX_RXKEY, 5, 64'h99_8877_6655);
		wr_n(cpr_pkg::IDX_SEED, 5, 64'h1f_2e3d_4c5b);
		wr_n(cpr_pkg::IDX_PIXEL, 3, 64'h33_2211);
		@(posedge hclk);
		check(64'(receiver_key_vector), 64'h99_8877_6655);
		check(64'(rng_seed_value), 64'h1f_2e3d_4c5b);
		exp_reg(cpr_pkg::IDX_SEED, 5, 64'h1f_2e3d_4c5b);
		exp_reg(cpr_pkg::IDX_PIXEL, 3, 64'h33_2211);
		// powerdown, mute, substitute video, cipher
		wr_n(cpr_pkg::IDX_CTRL, 1, 64'hb1);
		repeat (3) @(posedge hclk);
		check(64'(content_protect_powerdown), 64'h1);
		check(64'(cipher_on), 64'h1);
		check(64'(internal_compare_select), 64'h0);
		check(64'(audio_sample_out), 64'h0);
		check(64'(video_pixel_out), 64'h33_2211);
		exp_reg(cpr_pkg::IDX_CTRL, 1, 64'hb1);
		wr_n(cpr_pkg::IDX_CTRL, 1, 64'h0);
		repeat (3) @(posedge hclk);
		check(64'(content_protect_powerdown), 64'h0);
		check(64'(cipher_on), 64'h0);
		check(64'(audio_sample_out), 64'(audio_sample_in));
		check(64'(video_pixel_out), 64'(video_pixel_in));
		// self-clearing engine reset and handshake start
		wr_n(cpr_pkg::IDX_CTRL, 1, 64'h0c);
		@(posedge hclk);
		check(64'(protection_engine_reset), 64'h1);
		check(64'(begin_handshake), 64'h1);
		exp_reg(cpr_pkg::IDX_CTRL, 1, 64'h0c);
		engine_reset_done <= 1'b1;
		@(posedge hclk);
		engine_reset_done <= 1'b0;
		@(posedge hclk);
		check(64'(protection_engine_reset), 64'h0);
		check(64'(begin_handshake), 64'h1);
		handshake_began <= 1'b1;
		@(posedge hclk);
		handshake_began <= 1'b0;
		@(posedge hclk);
		check(64'(begin_handshake), 64'h0);
		exp_reg(cpr_pkg::IDX_CTRL, 1, 64'h0);
		// frame sync falling edge
		vsync_in <= 1'b1;
		repeat (4) @(posedge hclk);
		vsync_in <= 1'b0;
		repeat (6) @(posedge hclk);
		exp_reg(cpr_pkg::IDX_CTRL, 1, 64'h02);
		wr_n(cpr_pkg::IDX_CTRL, 1, 64'h0);
		exp_reg(cpr_pkg::IDX_CTRL, 1, 64'h0);
		// internal comparison mode
		wr_n(cpr_pkg::IDX_CTRL, 1, 64'h40);
		@(posedge hclk);
		check(64'(internal_compare_select), 64'h1);
		exp_reg(cpr_pkg::IDX_LINKCHK, 2, 64'hffff);
		exp_reg(cpr_pkg::IDX_ENHCHK, 1, 64'hff);
		exp_reg(cpr_pkg::IDX_DIGEST, 4, 64'h0);
		exp_reg(cpr_pkg::IDX_STATUS, 1, 64'h0);
		wr_n(cpr_pkg::IDX_LINKCHK, 2, 64'h1234);
		wr_n(cpr_pkg::IDX_ENHCHK, 1, 64'h56);
		wr_n(cpr_pkg::IDX_DIGEST, 4, 64'h89ab_cdef);
		exp_reg(cpr_pkg::IDX_LINKCHK, 2, 64'h1234);
		exp_reg(cpr_pkg::IDX_DIGEST, 4, 64'h89ab_cdef);
		exp_reg(cpr_pkg::IDX_STATUS, 1, 64'h0e);
		tx_link_check <= 16'h1235;
		receiver_key_bad <= 1'b1;
		@(posedge hclk);
		exp_reg(cpr_pkg::IDX_STATUS, 1, 64'h0d);
		wr_n(cpr_pkg::IDX_CTRL, 1, 64'h0);
		exp_reg(cpr_pkg::IDX_STATUS, 1, 64'h01);
		exp_reg(cpr_pkg::IDX_LINKCHK, 2, 64'h1235);
		// repeater capability bit
		wr_n(cpr_pkg::IDX_RXCAPS, 1, 64'hff);
		@(posedge hclk);
		check(64'(repeater), 64'h1);
		exp_reg(cpr_pkg::IDX_RXCAPS, 1, 64'h01);
		close_out;
	end
endmodule
